// ---- design/fsps_cfg.svh ----
// Purpose: constants for the flash self-program sequencer
// Assumes: APB word registers, 200 MHz clock
// Notes: offsets are byte addresses
`ifndef FSPS_CFG_SVH
`define FSPS_CFG_SVH
`define FSPS_OFF_CTRL 12'h000
`define FSPS_OFF_ZPTR 12'h004
`define FSPS_OFF_EXT 12'h008
`define FSPS_OFF_DATA 12'h00C
`define FSPS_OFF_CMD 12'h010
`define FSPS_OFF_STAT 12'h014
`define FSPS_OFF_LOCK 12'h018
`define FSPS_OFF_RVEC 12'h01C
`define FSPS_OFF_RDAT 12'h020
`define FSPS_BIT_OPEN 0
`define FSPS_BIT_ERASE 1
`define FSPS_BIT_WRITE 2
`define FSPS_BIT_LOCK 3
`define FSPS_BIT_REEN 4
`define FSPS_BIT_BUSY 6
`define FSPS_BIT_IEN 7
`define FSPS_CMD_MASK 8'h7F
`define FSPS_CMD_LOAD 8'h01
`define FSPS_CMD_ERASE 8'h03
`define FSPS_CMD_WRITE 8'h05
`define FSPS_CMD_LOCK 8'h09
`define FSPS_CMD_REEN 8'h11
`define FSPS_WINDOW 4
`define FSPS_APP_VECTOR 16'h0000
`define FSPS_PROG_NS 3700
`define FSPS_CLK_MHZ 200
`define FSPS_PROG_CYC ((`FSPS_PROG_NS * `FSPS_CLK_MHZ + 999) / 1000)
`endif

// ---- design/fsps_pkg.sv ----
// Purpose: types for the flash self-program sequencer
// Assumes: nothing
// Notes: state and operation types only
package fsps_pkg;
  typedef enum logic [1:0] {FSPS_IDLE, FSPS_ARMED, FSPS_PROG} fsps_state_type;
  typedef enum logic [1:0] {FSPS_OP_NONE, FSPS_OP_ERASE, FSPS_OP_WRITE, FSPS_OP_LOCK} fsps_op_type;
endpackage

// ---- design/fsps_sequencer.sv ----
// Purpose: self-programming sequencer with page buffer, APB registers
// Assumes: store strobe from the core, one 200 MHz clock, sync reset
// Notes: flash array is outside; this block issues erase/write pulses
// Behaviour
// - Fuse selects application or boot reset vector
// - Fuse cannot be changed by software
// - Z word bits address slot, rest page
// - Address latched when operation starts
// - Lock set ignores Z and extension
// - Load instruction addresses flash bytes via Z0
// - Buffer words loadable in any order
// - Erase pattern plus store within four cycles
// - Blocked-section erase halts CPU
// - Load pattern plus store writes buffer word
// - Buffer clears on write, reenable, reset
// - EEPROM write discards loaded words
// - Write pattern plus store within four cycles
// - Blocked-section write halts CPU
// - Interrupt held while enable bit clear
// - Busy flag set, readable section blocked
// - Busy cleared only by reenable bit
// - Lock pattern plus store sets lock bits
`timescale 1ns/1ps
`include "fsps_cfg.svh"
module fsps_sequencer #(
  parameter int WORD_BITS = 7,
  parameter int PAGE_BITS = 9,
  parameter logic [15:0] BOOT_VECTOR = 16'hF000,
  parameter int PROG_CYCLES = `FSPS_PROG_CYC,
  parameter int RWW_PAGES = 448
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic bootResetFuse,
  input wire logic storeStrobe,
  input wire logic eepromWrite,
  output logic [15:0] resetVector,
  output logic cpuHalt,
  output logic readableBlocked,
  output logic flashErase,
  output logic flashWrite,
  output logic [PAGE_BITS-1:0] flashPage,
  output logic irq
);
  localparam int BUF_WORDS = 1 << WORD_BITS;
  // ==========================================================
  // Registers
  logic [7:0] ctrl_reg;
  logic [15:0] zptr_reg;
  logic [7:0] ext_reg;
  logic [15:0] data_reg;
  logic [5:0] lock_reg;
  logic [1:0] fuseMeta_reg, fuseSync_reg;
  logic [1:0] eeMeta_reg, eeSync_reg;
  logic [2:0] window_reg;
  logic [31:0] progCnt_reg;
  logic [PAGE_BITS-1:0] page_reg;
  logic busy_reg, halt_reg, irq_reg;
  logic [15:0] pageBuf [BUF_WORDS];
  logic [BUF_WORDS-1:0] loaded_reg;
  fsps_pkg::fsps_state_type state_reg;
  fsps_pkg::fsps_op_type op_reg;
  // ==========================================================
  // Bus decode
  wire access = psel && penable;
  wire wrCtrl = access && pwrite && paddr == `FSPS_OFF_CTRL;
  wire wrZ = access && pwrite && paddr == `FSPS_OFF_ZPTR;
  wire wrExt = access && pwrite && paddr == `FSPS_OFF_EXT;
  wire wrData = access && pwrite && paddr == `FSPS_OFF_DATA;
  wire mapped = paddr == `FSPS_OFF_CTRL || paddr == `FSPS_OFF_ZPTR ||
    paddr == `FSPS_OFF_EXT || paddr == `FSPS_OFF_DATA || paddr == `FSPS_OFF_CMD ||
    paddr == `FSPS_OFF_STAT || paddr == `FSPS_OFF_LOCK || paddr == `FSPS_OFF_RVEC ||
    paddr == `FSPS_OFF_RDAT;
  wire [7:0] cmdBits = ctrl_reg & `FSPS_CMD_MASK;
  wire [7:0] wrCmd = pwdata[7:0] & `FSPS_CMD_MASK;
  // Store strobe is a core pulse on this clock
  wire storeHit = storeStrobe && state_reg == fsps_pkg::FSPS_ARMED;
  wire doLoad = storeHit && cmdBits == `FSPS_CMD_LOAD;
  wire doErase = storeHit && cmdBits == `FSPS_CMD_ERASE;
  wire doWrite = storeHit && cmdBits == `FSPS_CMD_WRITE;
  wire doLock = storeHit && cmdBits == `FSPS_CMD_LOCK;
  wire doReen = storeHit && cmdBits == `FSPS_CMD_REEN;
  // Last of the four store cycles after the control write, counted from zero
  wire timeout = state_reg == fsps_pkg::FSPS_ARMED && !storeStrobe &&
    window_reg == 3'(`FSPS_WINDOW - 1);
  wire progDone = state_reg == fsps_pkg::FSPS_PROG && progCnt_reg == 32'(PROG_CYCLES - 1);
  // Page from extension and Z high bits, word from Z low bits
  wire [23:0] fullAddr = {ext_reg, zptr_reg};
  wire [WORD_BITS-1:0] wordSel = fullAddr[WORD_BITS:1];
  wire [PAGE_BITS-1:0] pageSel = fullAddr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  // EEPROM write also beats a load that lands while it runs
  wire clearBuf = doReen || (progDone && op_reg == fsps_pkg::FSPS_OP_WRITE) ||
    eeSync_reg[1];
  // Byte read of buffer, Z0 picks high or low; an unloaded slot reads zero
  wire [15:0] rdWord = loaded_reg[wordSel] ? pageBuf[wordSel] : 16'h0000;
  wire [7:0] rdByte = zptr_reg[0] ? rdWord[15:8] : rdWord[7:0];
  wire [7:0] stat = {ctrl_reg[7], busy_reg, 1'b0, ctrl_reg[4:0]};
  wire [31:0] rdMux =
    paddr == `FSPS_OFF_CTRL ? {24'h000000, stat} :
    paddr == `FSPS_OFF_ZPTR ? {16'h0000, zptr_reg} :
    paddr == `FSPS_OFF_EXT ? {24'h000000, ext_reg} :
    paddr == `FSPS_OFF_DATA ? {16'h0000, data_reg} :
    paddr == `FSPS_OFF_STAT ? {24'h000000, stat} :
    paddr == `FSPS_OFF_LOCK ? {26'h0000000, lock_reg} :
    paddr == `FSPS_OFF_RVEC ? {16'h0000, resetVector} :
    paddr == `FSPS_OFF_RDAT ? {24'h000000, rdByte} : 32'h00000000;
  // ==========================================================
  // APB answer, no wait states: pready registered from the setup cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= rdMux;
      pslverr <= psel && !penable && !mapped;
    end
  end
  // Synchronisers for fuse and EEPROM write level
  always_ff @(posedge clock) begin
    if (rst) begin
      fuseMeta_reg <= 2'h3; // Unprogrammed level, no false boot vector
      fuseSync_reg <= 2'h3;
      eeMeta_reg <= 2'h0;
      eeSync_reg <= 2'h0;
    end else begin
      fuseMeta_reg <= {fuseMeta_reg[0], bootResetFuse};
      fuseSync_reg <= {fuseSync_reg[0], fuseMeta_reg[1]};
      eeMeta_reg <= {eeMeta_reg[0], eepromWrite};
      eeSync_reg <= {eeSync_reg[0], eeMeta_reg[1]};
    end
  end
  // Reset vector follows the fuse pin only, no software path
  always_ff @(posedge clock) begin
    if (rst) begin
      resetVector <= `FSPS_APP_VECTOR;
    end else begin
      resetVector <= fuseSync_reg[1] ? `FSPS_APP_VECTOR : BOOT_VECTOR;
    end
  end
  // Software data registers
  always_ff @(posedge clock) begin
    if (rst) begin
      zptr_reg <= 16'h0000;
      ext_reg <= 8'h00;
      data_reg <= 16'h0000;
    end else begin
      if (wrZ && pready) zptr_reg <= pwdata[15:0];
      if (wrExt && pready) ext_reg <= pwdata[7:0];
      if (wrData && pready) data_reg <= pwdata[15:0];
    end
  end
  // Control register and command sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= 8'h00;
      state_reg <= fsps_pkg::FSPS_IDLE;
      window_reg <= 3'h0;
      op_reg <= fsps_pkg::FSPS_OP_NONE;
    end else begin
      unique case (state_reg)
        fsps_pkg::FSPS_IDLE: begin
          if (wrCtrl && pready) begin
            ctrl_reg <= {pwdata[7], 1'b0, 1'b0, wrCmd[4:0]};
            window_reg <= 3'h0;
            if (wrCmd[0] && !eeSync_reg[1]) state_reg <= fsps_pkg::FSPS_ARMED;
          end
        end
        fsps_pkg::FSPS_ARMED: begin
          window_reg <= window_reg + 3'h1;
          if (doErase || doWrite || doLock) begin
            state_reg <= fsps_pkg::FSPS_PROG;
            op_reg <= doErase ? fsps_pkg::FSPS_OP_ERASE :
              doWrite ? fsps_pkg::FSPS_OP_WRITE : fsps_pkg::FSPS_OP_LOCK;
          end else if (storeHit || timeout) begin
            ctrl_reg[4:0] <= 5'h00;
            state_reg <= fsps_pkg::FSPS_IDLE;
          end
          if (wrCtrl && pready) ctrl_reg[7] <= pwdata[7];
        end
        fsps_pkg::FSPS_PROG: begin
          if (progDone) begin
            ctrl_reg[4:0] <= 5'h00;
            state_reg <= fsps_pkg::FSPS_IDLE;
            op_reg <= fsps_pkg::FSPS_OP_NONE;
          end
          if (wrCtrl && pready) ctrl_reg[7] <= pwdata[7];
        end
      endcase
    end
  end
  // Programming timer, page latch, busy and halt
  always_ff @(posedge clock) begin
    if (rst) begin
      progCnt_reg <= 32'h00000000;
      page_reg <= '0;
      busy_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      progCnt_reg <= state_reg == fsps_pkg::FSPS_PROG ? progCnt_reg + 32'h1 : 32'h0;
      if (doErase || doWrite) begin
        page_reg <= pageSel;
        busy_reg <= 1'b1;
        halt_reg <= 32'(pageSel) >= RWW_PAGES;
      end else if (progDone) begin
        halt_reg <= 1'b0;
      end
      if (doReen && !(doErase || doWrite)) busy_reg <= 1'b0;
    end
  end
  // Lock bits can only be programmed (cleared)
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_reg <= 6'h3F;
    end else if (doLock) begin
      lock_reg <= lock_reg & {data_reg[5:2], 2'h3};
    end
  end
  // Page buffer, random word order
  always_ff @(posedge clock) begin
    if (rst || clearBuf) begin
      loaded_reg <= '0;
    end else if (doLoad) begin
      loaded_reg[wordSel] <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (doLoad) pageBuf[wordSel] <= data_reg;
  end
  // Flash strobes and status outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      flashErase <= 1'b0;
      flashWrite <= 1'b0;
      flashPage <= '0;
      cpuHalt <= 1'b0;
      readableBlocked <= 1'b0;
      irq <= 1'b0;
    end else begin
      flashErase <= progDone && op_reg == fsps_pkg::FSPS_OP_ERASE;
      flashWrite <= progDone && op_reg == fsps_pkg::FSPS_OP_WRITE;
      flashPage <= page_reg;
      cpuHalt <= halt_reg;
      readableBlocked <= busy_reg;
      irq <= ctrl_reg[7] && !ctrl_reg[0];
    end
  end
  // ==========================================================
  // Checks
  a_erase_sets_busy: assert property (@(posedge clock) disable iff (rst)
    doErase |=> busy_reg) else $error("erase did not set busy");
  a_busy_holds: assert property (@(posedge clock) disable iff (rst)
    busy_reg && !doReen |=> busy_reg) else $error("busy dropped without reenable");
  a_irq_level: assert property (@(posedge clock) disable iff (rst)
    ctrl_reg[7] && !ctrl_reg[0] |=> irq) else $error("interrupt not held");
  a_window_timeout: assert property (@(posedge clock) disable iff (rst)
    ($rose(state_reg == fsps_pkg::FSPS_ARMED) ##0 (!storeStrobe) [*4]) |=> !ctrl_reg[0])
    else $error("window did not close");
  a_page_latched: assert property (@(posedge clock) disable iff (rst)
    state_reg == fsps_pkg::FSPS_PROG && $past(state_reg) == fsps_pkg::FSPS_PROG
    |-> $stable(page_reg)) else $error("page changed mid operation");
  a_buffer_clear: assert property (@(posedge clock) disable iff (rst)
    doReen |=> loaded_reg == '0) else $error("buffer not cleared");
  a_vector_fuse: assert property (@(posedge clock) disable iff (rst)
    fuseSync_reg[1] |=> resetVector == `FSPS_APP_VECTOR) else $error("bad vector");
  a_halt_blocked: assert property (@(posedge clock) disable iff (rst)
    halt_reg |-> busy_reg) else $error("halt without busy");
  // Halt, busy, interrupt, buffer, blocked-section and lock checks
  a_halt_clears: assert property (@(posedge clock) disable iff (rst)
    progDone |=> !halt_reg)
    else $error("halt held after operation");
  a_reen_clears_busy: assert property (@(posedge clock) disable iff (rst)
    doReen |=> !busy_reg)
    else $error("busy not cleared by reenable");
  a_irq_quiet: assert property (@(posedge clock) disable iff (rst)
    ctrl_reg[0] |=> !irq)
    else $error("interrupt while enable set");
  a_ee_discard: assert property (@(posedge clock) disable iff (rst)
    eeSync_reg[1] |=> loaded_reg == '0)
    else $error("loaded words kept over EEPROM write");
  a_blocked_follows: assert property (@(posedge clock) disable iff (rst)
    busy_reg |=> readableBlocked)
    else $error("section not blocked while busy");
  a_lock_bits_sticky: assert property (@(posedge clock) disable iff (rst)
    (lock_reg & ~$past(lock_reg)) == 6'h00)
    else $error("lock bit returned to unprogrammed");
endmodule

// ---- dv/fsps_testbench.sv ----
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: APB slave answers with pready; short programming count
// Notes: each scenario task drives the block and judges the result
`timescale 1ns/1ps
`include "fsps_cfg.svh"
module testbench;
  localparam int PROG = 8;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic bootResetFuse, storeStrobe, eepromWrite, cpuHalt, readableBlocked;
  logic flashErase, flashWrite, irq;
  logic [15:0] resetVector;
  logic [8:0] flashPage;
  int errTotal, nTests;
  // ==========================================
  // Design and clock
  fsps_sequencer #(.PROG_CYCLES(PROG)) fsps_sequencer_i (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .bootResetFuse(bootResetFuse),
    .storeStrobe(storeStrobe), .eepromWrite(eepromWrite), .resetVector(resetVector),
    .cpuHalt(cpuHalt), .readableBlocked(readableBlocked), .flashErase(flashErase),
    .flashWrite(flashWrite), .flashPage(flashPage), .irq(irq));
  // Free-running 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ==========================================
  // Shared tasks
  task automatic testDone();
    $display("errors %0d of %0d checks", errTotal, nTests);
    if (errTotal == 0 && nTests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // APB transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check(n < 50, 1, "no pready");
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control write followed by one store strobe in the next cycle
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, `FSPS_OFF_CTRL, {24'h000000, c});
    storeStrobe <= 1'b1;
    @(posedge clock);
    storeStrobe <= 1'b0;
  endtask
  task automatic setZ(input logic [15:0] z, input logic [31:0] ext);
    apb(1'b1, `FSPS_OFF_ZPTR, {16'h0000, z});
    apb(1'b1, `FSPS_OFF_EXT, ext);
  endtask
  task automatic loadWord(input logic [15:0] z, input logic [15:0] w);
    setZ(z, 32'h00000000);
    apb(1'b1, `FSPS_OFF_DATA, {16'h0000, w});
    cmd(`FSPS_CMD_LOAD);
  endtask
  task automatic readByte(input logic [15:0] z, input logic [7:0] exp);
    apb(1'b1, `FSPS_OFF_ZPTR, {16'h0000, z});
    apb(1'b0, `FSPS_OFF_RDAT, 32'h00000000);
    check(rd[7:0], exp, "buffer byte");
  endtask
  // Bounded wait for the erase or write pulse, then the latched page
  task automatic waitOp(input logic er, input logic [8:0] page);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((er ? flashErase : flashWrite) !== 1'b1 && n < 100);
    check(n < 100, 1, "operation pulse");
    check(flashPage, page, "latched page");
  endtask
  // ==========================================
  // Scenarios
  task automatic fuseVec();
    check(resetVector, `FSPS_APP_VECTOR, "app vector");
    bootResetFuse <= 1'b0;
    repeat (6) @(posedge clock);
    check(resetVector, 16'hF000, "boot vector");
    apb(1'b1, `FSPS_OFF_RVEC, 32'h00000000);
    apb(1'b0, `FSPS_OFF_RVEC, 32'h00000000);
    check(rd, 32'h0000F000, "vector stays");
    bootResetFuse <= 1'b1;
    repeat (5) @(posedge clock);
  endtask
  task automatic bufOrder();
    loadWord(16'h000A, 16'hBEEF);
    loadWord(16'h0004, 16'h1234);
    readByte(16'h000B, 8'hBE);
    readByte(16'h0004, 8'h34);
  endtask
  task automatic eraseWrite();
    setZ(16'h2500, 32'h00000000);
    cmd(8'h83);
    apb(1'b1, `FSPS_OFF_ZPTR, 32'h0000FF00);
    apb(1'b0, `FSPS_OFF_CTRL, 32'h00000000);
    check(rd[6], 1, "busy while erasing");
    check(irq, 0, "irq while enabled");
    check(readableBlocked, 1, "section blocked");
    check(cpuHalt, 0, "readable page no halt");
    waitOp(1'b1, 9'h025);
    repeat (3) @(posedge clock);
    check(irq, 1, "irq after done");
    apb(1'b0, `FSPS_OFF_CTRL, 32'h00000000);
    check(rd[6:0], 7'h40, "self clear, busy held");
    apb(1'b1, `FSPS_OFF_ZPTR, 32'h00002500);
    cmd(8'h05);
    waitOp(1'b0, 9'h025);
    readByte(16'h000B, 8'h00);
    loadWord(16'h0020, 16'h7788);
    cmd(`FSPS_CMD_REEN);
    repeat (PROG + 4) @(posedge clock);
    apb(1'b0, `FSPS_OFF_CTRL, 32'h00000000);
    check(rd[6], 0, "busy cleared");
    check(readableBlocked, 0, "section free");
    readByte(16'h0020, 8'h00);
  endtask
  task automatic haltPage();
    setZ(16'hC200, 32'h00000001);
    cmd(`FSPS_CMD_ERASE);
    repeat (2) @(posedge clock);
    check(cpuHalt, 1, "halt on erase");
    waitOp(1'b1, 9'h1C2);
    repeat (2) @(posedge clock);
    check(cpuHalt, 0, "halt released");
    cmd(`FSPS_CMD_WRITE);
    repeat (2) @(posedge clock);
    check(cpuHalt, 1, "halt on write");
    waitOp(1'b0, 9'h1C2);
    cmd(`FSPS_CMD_REEN);
    repeat (PROG + 4) @(posedge clock);
  endtask
  task automatic windowLock();
    apb(1'b1, `FSPS_OFF_CTRL, 32'h00000003);
    repeat (6) @(posedge clock);
    apb(1'b0, `FSPS_OFF_CTRL, 32'h00000000);
    check(rd[4:0], 5'h00, "window expired");
    setZ(16'hFFFF, 32'h00000001);
    apb(1'b1, `FSPS_OFF_DATA, 32'h000000C3);
    cmd(`FSPS_CMD_LOCK);
    repeat (PROG + 4) @(posedge clock);
    apb(1'b0, `FSPS_OFF_LOCK, 32'h00000000);
    check(rd[5:2], 4'h0, "lock bits set");
    check(flashPage, 9'h1C2, "lock ignores Z");
  endtask
  task automatic discards();
    loadWord(16'h0030, 16'hA55A);
    eepromWrite <= 1'b1;
    repeat (4) @(posedge clock);
    eepromWrite <= 1'b0;
    repeat (4) @(posedge clock);
    readByte(16'h0030, 8'h00);
    loadWord(16'h0040, 16'h6699);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    readByte(16'h0040, 8'h00);
    apb(1'b0, 12'h030, 32'h00000000);
    check(lastErr, 1, "unmapped address");
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    bootResetFuse = 1'b1;
    storeStrobe = 1'b0;
    eepromWrite = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    fuseVec();
    bufOrder();
    eraseWrite();
    haltPage();
    windowLock();
    discards();
    testDone();
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    errTotal++;
    $display("mismatch at %0t: watchdog expired", $time);
    testDone();
  end
endmodule
